/* src/pfs_pkg.sv */
package pfs_pkg;
   localparam int DW = 16;
   localparam int AW = 4;

   // Register indices on the plain register port
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_VOUT = 4'h1;
   localparam logic [3:0] REG_OV = 4'h2;
   localparam logic [3:0] REG_UV = 4'h3;
   localparam logic [3:0] REG_OC = 4'h4;
   localparam logic [3:0] REG_OT = 4'h5;
   localparam logic [3:0] REG_RESP = 4'h6;
   localparam logic [3:0] REG_TON_DLY = 4'h7;
   localparam logic [3:0] REG_TON_RISE = 4'h8;
   localparam logic [3:0] REG_RETRY_DLY = 4'h9;
   localparam logic [3:0] REG_FSW = 4'hA;
   localparam logic [3:0] REG_STATUS = 4'hB;
   localparam logic [3:0] REG_ADDR = 4'hC;

   // Field positions
   localparam int CTRL_ON = 0;
   localparam int CTRL_OFF = 1;
   localparam int RESP_UV_LATCH = 0;
   localparam int RESP_OV_RETRY = 1;
   localparam int RESP_OC_RETRY = 2;
   localparam int RESP_OT_RETRY = 3;
   localparam int RESP_DLY_EN = 4;
   localparam int RESP_PEER_TX = 5;
   localparam int RESP_PEER_RX = 6;

   // Reset values (mV, mA, degC, us, kHz)
   localparam logic [15:0] VOUT_RST = 16'h04B0;
   localparam int OV_PCT = 15;
   localparam logic [15:0] OV_RST = 16'(VOUT_RST + (VOUT_RST * OV_PCT) / 100);
   localparam logic [15:0] OC_RST = 16'h80E8;
   localparam logic [15:0] OT_RST = 16'h007D;
   localparam logic [15:0] OT_HYST = 16'h000F;
   localparam logic [15:0] RESP_RST = 16'h0000;
   localparam logic [15:0] TON_DLY_RST = 16'h0005;
   localparam logic [15:0] TON_RISE_RST = 16'h01F4;
   localparam logic [15:0] RETRY_DLY_RST = 16'h0064;
   localparam logic [15:0] FSW_RST = 16'h0215;

   // Address strap
   localparam logic [6:0] ADDR_BASE = 7'h19;
   localparam logic [6:0] ADDR_GND = 7'h26;
   localparam logic [6:0] ADDR_OPEN = 7'h28;
   localparam logic [4:0] ADDR_LAST_CODE = 5'h18;
   localparam logic [4:0] STRAP_GND = 5'h19;
   localparam logic [1:0] STRAP_WAIT = 2'h3;

   // Peak overcurrent
   localparam logic [2:0] PK_OC_COUNT = 3'h5;
   localparam logic [31:0] RIPPLE_SCALE = 32'h000F4240;

   // Timing
   localparam int CLK_NS = 40;
   localparam int US_NS = 1000;
   localparam logic [4:0] US_CYC = 5'((US_NS + CLK_NS - 1) / CLK_NS);
   localparam int PEER_PULSE_NS = 10000;
   localparam logic [8:0] PEER_GUARD = 9'h003;
   localparam logic [8:0] PEER_PULSE_CYC = 9'(PEER_PULSE_NS / CLK_NS);

   typedef struct packed {
      logic [15:0] vin_mv;
      logic [15:0] vout_mv;
      logic [15:0] iout_ma;
      logic [15:0] ipk_ma;
      logic [15:0] temp_c;
   } pfs_meas_t;

   typedef struct packed {
      logic peer;
      logic ot;
      logic oc;
      logic ov;
      logic uv;
   } pfs_flt_t;

   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_DELAY = 3'b001,
      ST_RAMP = 3'b011,
      ST_ON = 3'b010,
      ST_RETRY = 3'b110
   } pfs_state_t;

   function automatic logic [15:0] pfs_uv_strap(input logic [4:0] code);
      case (code)
         5'h00: pfs_uv_strap = 16'h1194;
         5'h01: pfs_uv_strap = 16'h2A30;
         5'h02: pfs_uv_strap = 16'h1054;
         5'h03: pfs_uv_strap = 16'h11EE;
         5'h04: pfs_uv_strap = 16'h13C4;
         5'h05: pfs_uv_strap = 16'h15C2;
         5'h06: pfs_uv_strap = 16'h17F2;
         5'h07: pfs_uv_strap = 16'h1A5E;
         5'h08: pfs_uv_strap = 16'h1CFC;
         5'h09: pfs_uv_strap = 16'h1FF4;
         5'h0A: pfs_uv_strap = 16'h231E;
         5'h0B: pfs_uv_strap = 16'h26AC;
         5'h0C: pfs_uv_strap = 16'h2A94;
         5'h0D: pfs_uv_strap = 16'h2EE0;
         5'h0E: pfs_uv_strap = 16'h3390;
         5'h0F: pfs_uv_strap = 16'h38CC;
         5'h10: pfs_uv_strap = 16'h3E80;
         default: pfs_uv_strap = 16'h1194;
      endcase
   endfunction
endpackage

/* src/pfs_supervisor.sv */
// Contract
// - Operation inhibited while input voltage sits below the lockout threshold.
// - Input undervoltage fault takes the configured response.
// - Bus address comes from the strap code, 19h to 31h contiguous.
// - Strap grounded answers at 26h, strap open answers at 28h.
// - Overvoltage flagged above a limit defaulting to target plus 15%.
// - Overvoltage shuts down at once; retry only if configured.
// - Output voltage sampled before the ramp starts.
// - Pre-bias below target: target starts there, drivers on, ramp up.
// - Below-target ramp ends exactly at the configured ramp time.
// - Pre-bias above target: target set there, drivers on, duty preloaded.
// - Above target: power-good at ramp end, then ramp down to target.
// - Pre-bias above overvoltage limit: no turn-on, overvoltage fault declared.
// - Average limit from register; peak threshold derived from vin, fsw, vout.
// - Five consecutive peak crossings shut down immediately.
// - Overcurrent stays off unless overcurrent retry is configured.
// - Temperature compared continuously; shutdown above limit, default 125 C.
// - Over-temperature stays off unless over-temperature retry is configured.
// - Retry waits configured delay, restarts only 15 C below the limit.
// - Still too hot on a check: wait again and repeat.
// - Faults and restarts exchanged with peers over one shared wire.
// - Start-up delay timed from enable; ramp only after it expires.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module pfs_supervisor #(
   parameter int INDUCT_NH = 300
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [pfs_pkg::AW-1:0] reg_addr,
   input wire logic [pfs_pkg::DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [pfs_pkg::DW-1:0] reg_rdata,
   input wire logic enable_pin,
   input wire logic [4:0] address_strap_pin,
   input wire logic [4:0] input_undervoltage_lockout_strap_pin,
   input wire logic sw_cycle_tick,
   input wire pfs_pkg::pfs_meas_t meas,
   input wire logic peer_fault_bus_in,
   output logic peer_fault_bus_out,
   output logic peer_fault_bus_oe,
   output logic power_good_output,
   output logic drivers_en,
   output logic [15:0] target_mv,
   output logic [15:0] preload_mv,
   output logic preload_strobe,
   output logic [6:0] smbus_address
);
   import pfs_pkg::*;

   logic [12:0] sync1;
   logic [12:0] sync2;
   logic en_s;
   logic tick_s;
   logic peer_s;
   logic [4:0] addr_code;
   logic [4:0] uv_code;
   logic tick_prev;
   logic en_prev;

   logic [15:0] vout_tgt;
   logic [15:0] ov_lim;
   logic [15:0] uv_cmd;
   logic uv_cmd_sel;
   logic [15:0] oc_lim;
   logic [15:0] ot_lim;
   logic [15:0] resp;
   logic [15:0] ton_dly;
   logic [15:0] ton_rise;
   logic [15:0] retry_dly;
   logic [15:0] fsw_khz;
   pfs_flt_t status;
   logic [15:0] next_rdata;

   logic [1:0] strap_cnt;
   logic strap_done;
   logic [15:0] uv_strap_mv;
   logic [15:0] uv_thr;

   logic [4:0] us_div;
   logic us_tick;

   pfs_state_t state;
   logic run_req;
   logic ramp_up;
   logic [15:0] ramp_diff;
   logic [21:0] acc;
   logic [21:0] next_acc;
   logic [20:0] cyc_cnt;
   logic [20:0] rise_cyc;
   logic [15:0] cnt_us;
   logic retry_ot;
   logic [15:0] ot_rearm;

   logic [16:0] ipk_excess;
   logic [15:0] vin_drop;
   logic [79:0] pk_lhs;
   logic [79:0] pk_rhs;
   logic pk_over;
   logic [2:0] pk_cnt;

   logic [8:0] peer_cnt;
   logic [8:0] next_peer_cnt;

   logic wr_ctrl;
   logic on_cmd;
   logic off_cmd;
   logic en_rise;
   logic stop_req;
   logic running;
   logic dly_done;
   logic ov_hit;
   logic oc_hit;
   logic ot_hit;
   logic uv_hit;
   logic peer_hit;
   logic own_hit;
   logic shut;
   logic retry_sel;

   // Pins and straps pass two flops before use
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1 <= 13'h0000;
         sync2 <= 13'h0000;
         tick_prev <= 1'b0;
      end else begin
         sync1 <= {enable_pin, sw_cycle_tick, peer_fault_bus_in,
                   address_strap_pin, input_undervoltage_lockout_strap_pin};
         sync2 <= sync1;
         tick_prev <= tick_s;
      end
   end

   assign en_s = sync2[12];
   assign tick_s = sync2[11];
   assign peer_s = sync2[10];
   assign addr_code = sync2[9:5];
   assign uv_code = sync2[4:0];

   // Straps caught once, after the synchronisers have filled
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         strap_cnt <= 2'h0;
         strap_done <= 1'b0;
         smbus_address <= ADDR_OPEN;
         uv_strap_mv <= pfs_uv_strap(5'h00);
      end else if (!strap_done) begin
         if (strap_cnt == STRAP_WAIT) begin
            strap_done <= 1'b1;
            uv_strap_mv <= pfs_uv_strap(uv_code);
            if (addr_code <= ADDR_LAST_CODE) begin
               smbus_address <= ADDR_BASE + 7'(addr_code);
            end else if (addr_code == STRAP_GND) begin
               smbus_address <= ADDR_GND;
            end else begin
               smbus_address <= ADDR_OPEN;
            end
         end else begin
            strap_cnt <= strap_cnt + 2'h1;
         end
      end
   end

   // Writing the limit moves lockout from strap to register
   assign uv_thr = uv_cmd_sel ? uv_cmd : uv_strap_mv;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         vout_tgt <= VOUT_RST;
         ov_lim <= OV_RST;
         uv_cmd <= 16'h0000;
         uv_cmd_sel <= 1'b0;
         oc_lim <= OC_RST;
         ot_lim <= OT_RST;
         resp <= RESP_RST;
         ton_dly <= TON_DLY_RST;
         ton_rise <= TON_RISE_RST;
         retry_dly <= RETRY_DLY_RST;
         fsw_khz <= FSW_RST;
      end else if (reg_wr) begin
         unique case (reg_addr)
            REG_VOUT: vout_tgt <= reg_wdata;
            REG_OV: ov_lim <= reg_wdata;
            REG_UV: begin
               uv_cmd <= reg_wdata;
               uv_cmd_sel <= 1'b1;
            end
            REG_OC: oc_lim <= reg_wdata;
            REG_OT: ot_lim <= reg_wdata;
            REG_RESP: resp <= reg_wdata;
            REG_TON_DLY: ton_dly <= reg_wdata;
            REG_TON_RISE: ton_rise <= reg_wdata;
            REG_RETRY_DLY: retry_dly <= reg_wdata;
            REG_FSW: fsw_khz <= reg_wdata;
            default: ;
         endcase
      end
   end

   always_comb begin
      next_rdata = 16'h0000;
      if (reg_rd) begin
         unique case (reg_addr)
            REG_CTRL: next_rdata = 16'({power_good_output, drivers_en,
                                        run_req, state});
            REG_VOUT: next_rdata = vout_tgt;
            REG_OV: next_rdata = ov_lim;
            REG_UV: next_rdata = uv_thr;
            REG_OC: next_rdata = oc_lim;
            REG_OT: next_rdata = ot_lim;
            REG_RESP: next_rdata = resp;
            REG_TON_DLY: next_rdata = ton_dly;
            REG_TON_RISE: next_rdata = ton_rise;
            REG_RETRY_DLY: next_rdata = retry_dly;
            REG_FSW: next_rdata = fsw_khz;
            REG_STATUS: next_rdata = 16'(status);
            REG_ADDR: next_rdata = 16'(smbus_address);
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // Sticky fault flags; a set in the clearing cycle survives
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         status <= pfs_flt_t'(5'h00);
      end else begin
         status <= pfs_flt_t'((status & ~((reg_wr && reg_addr == REG_STATUS)
                   ? reg_wdata[4:0] : 5'h00))
                   | {peer_hit, ot_hit, oc_hit, ov_hit, uv_hit});
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         us_div <= 5'h00;
      end else begin
         // Held idle so a timed delay never starts mid-microsecond
         us_div <= (us_tick || shut || state == ST_OFF
                    || state == ST_RAMP) ? 5'h00 : us_div + 5'h01;
      end
   end
   assign us_tick = (us_div == US_CYC - 5'h01);

   // Peak threshold is avg limit plus half ripple; division avoided
   // by cross-multiplying ripple = (vin-vout)*vout/(vin*fsw*L)
   always_comb begin
      ipk_excess = (meas.ipk_ma > oc_lim) ?
                   17'(meas.ipk_ma - oc_lim) : 17'h00000;
      vin_drop = (meas.vin_mv > meas.vout_mv) ?
                 16'(meas.vin_mv - meas.vout_mv) : 16'h0000;
      pk_lhs = 80'(ipk_excess) * 80'(meas.vin_mv) * 80'(fsw_khz)
               * 80'(INDUCT_NH) * 80'h2;
      pk_rhs = 80'(vin_drop) * 80'(meas.vout_mv) * 80'(RIPPLE_SCALE);
      pk_over = (ipk_excess != 17'h00000) && (pk_lhs > pk_rhs);
   end

   // Consecutive switching cycles over the peak threshold
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pk_cnt <= 3'h0;
      end else if (!drivers_en) begin
         pk_cnt <= 3'h0;
      end else if (tick_s && !tick_prev) begin
         if (!pk_over) begin
            pk_cnt <= 3'h0;
         end else if (pk_cnt != PK_OC_COUNT) begin
            pk_cnt <= pk_cnt + 3'h1;
         end
      end
   end

   assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
   assign on_cmd = wr_ctrl && reg_wdata[CTRL_ON];
   assign off_cmd = wr_ctrl && reg_wdata[CTRL_OFF];
   assign en_rise = en_s && !en_prev;
   assign stop_req = off_cmd || (!en_s && en_prev);
   assign running = (state == ST_DELAY) || (state == ST_RAMP)
                    || (state == ST_ON);
   assign dly_done = (cnt_us >= ton_dly);
   assign rise_cyc = 21'(ton_rise) * 21'(US_CYC);
   assign next_acc = acc + 22'(ramp_diff);
   assign ot_rearm = (ot_lim > OT_HYST) ? 16'(ot_lim - OT_HYST) : 16'h0000;

   // Overvoltage also judged on the pre-bias sample at delay end
   assign ov_hit = (meas.vout_mv > ov_lim) && ((state == ST_RAMP)
                   || (state == ST_ON) || (state == ST_DELAY && dly_done));
   assign oc_hit = ((state == ST_RAMP) || (state == ST_ON))
                   && ((meas.iout_ma > oc_lim) || pk_cnt == PK_OC_COUNT);
   assign ot_hit = running && (meas.temp_c > ot_lim);
   assign uv_hit = running && (meas.vin_mv < uv_thr);
   assign peer_hit = running && !peer_s && (peer_cnt == 9'h000)
                     && resp[RESP_PEER_RX];
   assign own_hit = ov_hit || oc_hit || ot_hit;
   assign shut = own_hit || uv_hit || peer_hit;
   assign retry_sel = ov_hit ? resp[RESP_OV_RETRY] :
                      oc_hit ? resp[RESP_OC_RETRY] :
                      resp[RESP_OT_RETRY];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_OFF;
         run_req <= 1'b0;
         en_prev <= 1'b0;
         drivers_en <= 1'b0;
         power_good_output <= 1'b0;
         target_mv <= 16'h0000;
         preload_mv <= 16'h0000;
         preload_strobe <= 1'b0;
         ramp_up <= 1'b0;
         ramp_diff <= 16'h0000;
         acc <= 22'h000000;
         cyc_cnt <= 21'h000000;
         cnt_us <= 16'h0000;
         retry_ot <= 1'b0;
      end else begin
         en_prev <= en_s;
         preload_strobe <= 1'b0;
         if (en_rise || on_cmd) begin
            run_req <= 1'b1;
         end
         if (stop_req) begin
            state <= ST_OFF;
            run_req <= 1'b0;
            drivers_en <= 1'b0;
            power_good_output <= 1'b0;
         end else if (shut) begin
            drivers_en <= 1'b0;
            power_good_output <= 1'b0;
            cnt_us <= 16'h0000;
            retry_ot <= ot_hit && !ov_hit && !oc_hit;
            if (own_hit) begin
               state <= retry_sel ? ST_RETRY : ST_OFF;
               if (!retry_sel) begin
                  run_req <= 1'b0;
               end
            end else begin
               // Peer shutdown restarts through the normal delay
               state <= ST_OFF;
               if (uv_hit && resp[RESP_UV_LATCH]) begin
                  run_req <= 1'b0;
               end
            end
         end else begin
            unique case (state)
               ST_OFF: begin
                  // Peer line must be released before a restart
                  if (run_req && meas.vin_mv >= uv_thr
                      && meas.temp_c <= ot_lim && peer_s) begin
                     state <= ST_DELAY;
                     cnt_us <= 16'h0000;
                  end
               end
               ST_DELAY: begin
                  if (dly_done) begin
                     target_mv <= meas.vout_mv;
                     drivers_en <= 1'b1;
                     acc <= 22'h000000;
                     cyc_cnt <= 21'h000000;
                     state <= ST_RAMP;
                     if (meas.vout_mv < vout_tgt) begin
                        ramp_up <= 1'b1;
                        ramp_diff <= 16'(vout_tgt - meas.vout_mv);
                     end else begin
                        ramp_up <= 1'b0;
                        ramp_diff <= 16'h0000;
                        preload_mv <= meas.vout_mv;
                        preload_strobe <= 1'b1;
                     end
                  end else if (us_tick) begin
                     cnt_us <= cnt_us + 16'h0001;
                  end
               end
               ST_RAMP: begin
                  cyc_cnt <= cyc_cnt + 21'h000001;
                  if (cyc_cnt + 21'h000001 >= rise_cyc) begin
                     // Snap keeps the ramp time fixed whatever the start
                     if (ramp_up) begin
                        target_mv <= vout_tgt;
                     end
                     power_good_output <= 1'b1;
                     state <= ST_ON;
                  end else if (ramp_up) begin
                     if (next_acc >= 22'(rise_cyc)) begin
                        target_mv <= target_mv + 16'h0001;
                        acc <= next_acc - 22'(rise_cyc);
                     end else begin
                        acc <= next_acc;
                     end
                  end
               end
               ST_ON: begin
                  if (us_tick && target_mv > vout_tgt) begin
                     target_mv <= target_mv - 16'h0001;
                  end else if (us_tick && target_mv < vout_tgt) begin
                     target_mv <= target_mv + 16'h0001;
                  end
               end
               ST_RETRY: begin
                  if (!resp[RESP_DLY_EN] || cnt_us >= retry_dly) begin
                     if (retry_ot && meas.temp_c >= ot_rearm) begin
                        cnt_us <= 16'h0000;
                     end else begin
                        state <= ST_OFF;
                     end
                  end else if (us_tick) begin
                     cnt_us <= cnt_us + 16'h0001;
                  end
               end
               default: state <= ST_OFF;
            endcase
         end
      end
   end

   // Own fault pulls the peer wire low; the guard hides our own
   // release while it travels back through the synchroniser
   always_comb begin
      next_peer_cnt = peer_cnt;
      if (own_hit && !stop_req && resp[RESP_PEER_TX]
          && peer_cnt == 9'h000) begin
         next_peer_cnt = PEER_PULSE_CYC + PEER_GUARD;
      end else if (peer_cnt != 9'h000) begin
         next_peer_cnt = peer_cnt - 9'h001;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         peer_cnt <= 9'h000;
         peer_fault_bus_oe <= 1'b0;
         peer_fault_bus_out <= 1'b0;
      end else begin
         peer_cnt <= next_peer_cnt;
         peer_fault_bus_oe <= (next_peer_cnt > PEER_GUARD);
         peer_fault_bus_out <= 1'b0;
      end
   end
endmodule // pfs_supervisor

/* dv/pfs_properties.sv */
`timescale 1ns/1ps
module pfs_properties
   import pfs_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [pfs_pkg::AW-1:0] reg_addr,
   input wire logic [pfs_pkg::DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic enable_pin,
   input wire logic peer_fault_bus_oe,
   input wire logic power_good_output,
   input wire logic drivers_en,
   input wire logic preload_strobe,
   input wire logic [6:0] smbus_address
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   chk_pg_drivers:
   assert property (power_good_output |-> drivers_en) else $error("pg alone");
   chk_ramp_before_pg:
   assert property ($rose(drivers_en) |-> !power_good_output)
      else $error("pg at start");
   chk_preload_start:
   assert property (preload_strobe |-> $rose(drivers_en) ##1 !preload_strobe)
      else $error("preload strobe");
   chk_enable_delay:
   assert property ($rose(enable_pin) |-> !drivers_en [*3])
      else $error("no start delay");
   // Two edges allowed, though run request, state and drivers all clear on the first
   chk_off_cmd:
   assert property (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_OFF]
      |-> ##2 !drivers_en && !power_good_output) else $error("off ignored");
   chk_oe_pulse:
   assert property ($rose(peer_fault_bus_oe) |-> peer_fault_bus_oe [*8])
      else $error("peer pulse short");
   chk_oe_shutdown:
   assert property ($rose(peer_fault_bus_oe)
      |-> !drivers_en && !power_good_output) else $error("fault kept on");
   chk_addr_range:
   assert property (smbus_address >= 7'h19 && smbus_address <= 7'h31)
      else $error("address out of range");
endmodule // pfs_properties

bind pfs_supervisor pfs_properties u_props (.clk, .arst_n, .reg_addr,
   .reg_wdata, .reg_wr, .enable_pin, .peer_fault_bus_oe, .power_good_output,
   .drivers_en, .preload_strobe, .smbus_address);

/* dv/pfs_peer_model.sv */
`timescale 1ns/1ps
module pfs_peer_model (
   input wire logic clk,
   input wire logic fire,
   input wire logic dut_oe,
   output logic wire_lvl
);
   logic [8:0] hold = 9'h000;
   // Peer pulls low for one event pulse
   always @(posedge clk) begin
      if (fire) hold <= 9'h0FA;
      else if (hold != 9'h000) hold <= hold - 9'h001;
   end
   // Pull-up: released wire reads high
   assign wire_lvl = !(dut_oe || hold != 9'h000);
endmodule // pfs_peer_model

/* dv/pfs_supervisor_tb_top.sv */
`timescale 1ns/1ps
module pfs_supervisor_tb_top;
   import pfs_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic en = 1'b0;
   logic tick = 1'b0;
   logic fire = 1'b0;
   logic rdd = 1'b0;
   logic [3:0] ad = 4'h0;
   logic [15:0] wd = 16'h0;
   logic [4:0] sa = 5'h0;
   logic [4:0] ua = 5'h2;
   logic [31:0] seed = 32'h000182A0;
   pfs_meas_t m = {16'h2EE0, 16'h0, 16'h0, 16'h0, 16'h19};
   logic [15:0] rdq[$];
   int failures = 0;
   int checks = 0;
   wire wl, oe, pg, drv, po;
   wire [15:0] rdat, tgt, pm;
   wire [6:0] sma;
   always #20 clk = ~clk;
   pfs_peer_model peer (.clk(clk), .fire(fire), .dut_oe(oe), .wire_lvl(wl));
   pfs_supervisor DUT (.clk(clk), .arst_n(arst_n), .reg_addr(ad),
      .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
      .enable_pin(en), .address_strap_pin(sa), .input_undervoltage_lockout_strap_pin(ua),
      .sw_cycle_tick(tick), .meas(m), .peer_fault_bus_in(wl),
      .peer_fault_bus_out(po), .peer_fault_bus_oe(oe), .power_good_output(pg),
      .drivers_en(drv), .target_mv(tgt), .preload_mv(pm), .preload_strobe(),
      .smbus_address(sma));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic cmp(string n, logic [15:0] e, logic [15:0] s);
      checks++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic chk(string n, logic e, logic s);
      checks++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %b seen %b", n, e, s);
      end
   endtask
   task automatic cyc(int k);
      repeat (k) @(posedge clk);
   endtask
   // Idle cycle after each strobe keeps strobes single drivers per step
   task automatic bus(logic w, logic [3:0] a, logic [15:0] d);
      if (!w) rdq.push_back(d);
      ad <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wt(logic p, logic v, int lim, output int k);
      k = 0;
      while ((p ? pg : drv) !== v && k < lim) begin
         @(posedge clk);
         k++;
      end
   endtask
   task automatic wrap_up();
      if (failures == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      if (rdd) cmp("reg_rdata", rdq.pop_front(), rdat);
      rdd <= rd;
   end
   initial begin
      #500us;
      failures++;
      wrap_up();
   end
   initial begin
      int k;
      logic [15:0] v;
      for (int i = 0; i < 5; i++) begin
         k = i == 0 ? 25 : i == 1 ? 31 : i == 2 ? 0 : i == 3 ? 24 : xs() % 25;
         arst_n <= 1'b0;
         sa <= 5'(k);
         cyc(6);
         arst_n <= 1'b1;
         cyc(8);
         v = k == 25 ? 16'h26 : k == 31 ? 16'h28 : 16'(16'h19 + 16'(k));
         cmp("smbus_address", v, {9'h0, sma});
      end
      bus(1'b0, REG_OV, 16'h0564);
      bus(1'b0, REG_OT, 16'h7D);
      bus(1'b0, REG_RESP, 16'h0);
      bus(1'b0, REG_UV, 16'h1054);
      bus(1'b0, 4'hD, 16'h0);
      bus(1'b1, REG_TON_DLY, 16'h2);
      bus(1'b1, REG_TON_RISE, 16'h1);
      bus(1'b1, REG_RESP, 16'h20);
      v = 16'(xs() % 1100 + 50);
      m.vout_mv <= v;
      en <= 1'b1;
      wt(1'b0, 1'b1, 300, k);
      chk("start_delay", 1'b1, k >= 50 && k <= 64);
      cmp("target_mv", v, tgt);
      wt(1'b1, 1'b1, 100, k);
      cmp("ramp_cycles", 16'h19, 16'(k));
      cmp("target_mv", 16'h04B0, tgt);
      m.vout_mv <= 16'h0578;
      wt(1'b0, 1'b0, 20, k);
      chk("ov_shutdown", 1'b1, k < 4);
      chk("peer_tx", 1'b1, oe);
      chk("peer_out", 1'b0, po);
      m.vout_mv <= 16'h04B0;
      cyc(100);
      chk("latched", 1'b0, drv);
      en <= 1'b0;
      cyc(200);
      bus(1'b0, REG_STATUS, 16'h2);
      bus(1'b1, REG_STATUS, 16'h1F);
      bus(1'b1, REG_RESP, 16'h0);
      m.vout_mv <= 16'h0514;
      bus(1'b1, REG_CTRL, 16'h1);
      wt(1'b0, 1'b1, 100, k);
      cmp("preload_target", 16'h0514, tgt);
      cmp("preload_mv", 16'h0514, pm);
      wt(1'b1, 1'b1, 100, k);
      cmp("pg_above", 16'h19, 16'(k));
      cyc(60);
      chk("ramp_down", 1'b1, tgt < 16'h0514 && tgt >= 16'h04B0);
      m.ipk_ma <= 16'hFFFF;
      for (int i = 0; i < 5; i++) begin
         chk("oc_count", 1'b1, drv);
         tick <= 1'b1;
         cyc(3);
         tick <= 1'b0;
         cyc(3);
      end
      cyc(4);
      chk("oc_count", 1'b0, drv);
      m.ipk_ma <= 16'h0;
      bus(1'b0, REG_STATUS, 16'h4);
      chk("oc_latched", 1'b0, drv);
      bus(1'b1, REG_RESP, 16'h18);
      bus(1'b1, REG_RETRY_DLY, 16'h1);
      bus(1'b1, REG_CTRL, 16'h1);
      wt(1'b0, 1'b1, 100, k);
      m.temp_c <= 16'h82;
      wt(1'b0, 1'b0, 10, k);
      chk("ot_shutdown", 1'b1, k < 10);
      // Above the restart margin yet below the limit
      m.temp_c <= 16'h73;
      cyc(200);
      chk("ot_hold", 1'b0, drv);
      m.temp_c <= 16'h64;
      wt(1'b0, 1'b1, 300, k);
      chk("ot_restart", 1'b1, k < 300);
      m.vin_mv <= 16'h0FA0;
      wt(1'b0, 1'b0, 10, k);
      chk("uv_shutdown", 1'b1, k < 10);
      m.vin_mv <= 16'h2EE0;
      wt(1'b0, 1'b1, 300, k);
      chk("uv_restart", 1'b1, k < 300);
      bus(1'b1, REG_RESP, 16'h40);
      fire <= 1'b1;
      cyc(1);
      fire <= 1'b0;
      wt(1'b0, 1'b0, 10, k);
      chk("peer_shutdown", 1'b1, k < 10);
      wt(1'b0, 1'b1, 400, k);
      chk("peer_restart", 1'b1, k > 240 && k < 400);
      bus(1'b1, REG_CTRL, 16'h2);
      cyc(2);
      chk("off_cmd", 1'b0, drv);
      // Pre-bias above the overvoltage limit must never turn on
      m.vout_mv <= 16'h0578;
      en <= 1'b1;
      wt(1'b0, 1'b1, 300, k);
      chk("prebias_ov", 1'b1, k == 300);
      en <= 1'b0;
      m.vout_mv <= 16'h04B0;
      cyc(4);
      en <= 1'b1;
      wt(1'b0, 1'b1, 300, k);
      chk("enable_restart", 1'b1, k < 300);
      wrap_up();
   end
endmodule // pfs_supervisor_tb_top
